// File: core/fcdds_transfer_engine.sv
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "fcdds_map.svh"

module fcdds_transfer_engine (
  input  wire logic        CLK_I,        // System clock, 10 MHz
  input  wire logic        RST_I,        // Synchronous reset, active high
  input  wire logic        PSEL_I,       // APB select
  input  wire logic        PENABLE_I,    // APB access phase
  input  wire logic        PWRITE_I,     // APB write
  input  wire logic [11:0] PADDR_I,      // APB byte address
  input  wire logic [31:0] PWDATA_I,     // APB write data
  output logic [31:0]      PRDATA_O,     // APB read data
  output logic             PREADY_O,     // APB ready
  output logic             PSLVERR_O,    // APB error on unmapped address
  input  wire logic [31:0] TRIG_I,       // Trigger lines, eight per channel
  input  wire logic        CPU_BUS_REQ_I,// Core wants the data bus
  output logic             MEM_REQ_O,    // Data bus access request
  output logic             MEM_WE_O,     // Data bus write
  output logic [15:0]      MEM_ADDR_O,   // Data space byte address
  output logic [7:0]       MEM_WDATA_O,  // Write byte
  output logic [1:0]       MEM_REGION_O, // Decoded region of the address
  input  wire logic [7:0]  MEM_RDATA_I,  // Read byte
  input  wire logic        MEM_ACK_I,    // Access completes this cycle
  output logic             IRQ_O         // Interrupt, level
);

  typedef struct packed {
    fcdds_pkg::fcdds_state_t  st;
    logic [1:0]               ch;
    logic                     hold;
    logic [1:0]               rr_last;
    logic                     g_en;
    logic                     g_rr;
    logic                     g_eemap;
    logic [7:0]               istat;
    logic [7:0]               imask;
    logic                     mreq;
    logic                     mwe;
    logic [15:0]              maddr;
    logic [7:0]               mwdata;
    fcdds_pkg::fcdds_region_t mreg;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
    logic                     irq;
  } fcdds_top_t;

  fcdds_top_t  s;
  fcdds_top_t  n;

  logic [3:0]  ch_en;
  logic [3:0]  ch_pend;
  logic [3:0]  ch_done;
  logic [3:0]  ch_link;
  logic [15:0] ch_src  [4];
  logic [15:0] ch_dst  [4];
  logic [31:0] ch_ctrl [4];
  logic [31:0] ch_cnt  [4];

  logic        hit;
  logic        glob;
  logic        chsel;
  logic [31:0] rd_data;
  logic        commit;
  logic [3:0]  wr_ctrl;
  logic [3:0]  wr_src;
  logic [3:0]  wr_dst;
  logic [3:0]  wr_cnt;
  logic [3:0]  byte_done;
  logic [3:0]  abort;
  logic [1:0]  pick_ch;
  logic        any_pend;
  logic [7:0]  events;

  // Decode a data space address into its region
  function automatic fcdds_pkg::fcdds_region_t region(input logic [15:0] a);
    if (a <= `FCDDS_IO_END) begin
      return fcdds_pkg::FCDDS_RGN_IO;
    end
    if (a <= `FCDDS_EE_END) begin
      return fcdds_pkg::FCDDS_RGN_EE;
    end
    if (a >= `FCDDS_SRAM_BASE && a <= `FCDDS_SRAM_END) begin
      return fcdds_pkg::FCDDS_RGN_SRAM;
    end
    return fcdds_pkg::FCDDS_RGN_RSVD;
  endfunction

  // Pick the first pending channel at or after the base index
  function automatic logic [1:0] pick(input logic [3:0] p, input logic [1:0] base);
    logic [1:0] idx;
    logic [1:0] res;
    res = base;
    for (int i = 3; i >= 0; i--) begin
      idx = 2'(base + 2'(i));
      if (p[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction

  // APB address decode and read mux
  always_comb begin
    rd_data = 32'h0;
    glob    = (PADDR_I[11:4] == 8'h00) && (PADDR_I[1:0] == 2'h0);
    chsel   = (PADDR_I[11:6] == `FCDDS_CH_PAGE) && (PADDR_I[1:0] == 2'h0);
    hit     = glob || chsel;
    if (glob) begin
      unique case (PADDR_I)
        `FCDDS_GCTRL: rd_data = {29'h0, s.g_eemap, s.g_rr, s.g_en};
        `FCDDS_ISTAT: rd_data = {24'h0, s.istat};
        `FCDDS_IMASK: rd_data = {24'h0, s.imask};
        default:      rd_data = {21'h0, s.ch, s.st != fcdds_pkg::FCDDS_IDLE,
                                 ch_en, ch_pend};
      endcase
    end else if (chsel) begin
      unique case (PADDR_I[3:0])
        `FCDDS_CH_CTRL: rd_data = ch_ctrl[PADDR_I[5:4]];
        `FCDDS_CH_SRC:  rd_data = {16'h0, ch_src[PADDR_I[5:4]]};
        `FCDDS_CH_DST:  rd_data = {16'h0, ch_dst[PADDR_I[5:4]]};
        default:        rd_data = ch_cnt[PADDR_I[5:4]];
      endcase
    end
  end

  // Write strobes, taken at the edge that completes the access
  always_comb begin
    commit = PSEL_I && PENABLE_I && s.pready && PWRITE_I && hit;
    for (int c = 0; c < 4; c++) begin
      wr_ctrl[c] = commit && chsel && (PADDR_I[5:4] == 2'(c))
                   && (PADDR_I[3:0] == `FCDDS_CH_CTRL);
      wr_src[c]  = commit && chsel && (PADDR_I[5:4] == 2'(c))
                   && (PADDR_I[3:0] == `FCDDS_CH_SRC);
      wr_dst[c]  = commit && chsel && (PADDR_I[5:4] == 2'(c))
                   && (PADDR_I[3:0] == `FCDDS_CH_DST);
      wr_cnt[c]  = commit && chsel && (PADDR_I[5:4] == 2'(c))
                   && (PADDR_I[3:0] == `FCDDS_CH_CNT);
    end
  end

  // Channel arbitration
  always_comb begin
    any_pend = |ch_pend;
    if (s.hold && ch_pend[s.ch]) begin
      pick_ch = s.ch;
    end else if (s.g_rr) begin
      pick_ch = pick(ch_pend, 2'(s.rr_last + 2'h1));
    end else begin
      pick_ch = pick(ch_pend, 2'h0);
    end
  end

  // Per channel byte completion and abort strobes
  always_comb begin
    byte_done = 4'h0;
    abort     = 4'h0;
    if (s.st == fcdds_pkg::FCDDS_WR && MEM_ACK_I) begin
      byte_done[s.ch] = 1'b1;
    end
    if (s.st == fcdds_pkg::FCDDS_IDLE && s.g_en && any_pend && !CPU_BUS_REQ_I) begin
      if (region(ch_src[pick_ch]) == fcdds_pkg::FCDDS_RGN_RSVD
          || (region(ch_src[pick_ch]) == fcdds_pkg::FCDDS_RGN_EE && !s.g_eemap)) begin
        abort[pick_ch] = 1'b1;
      end
    end
    if (s.st == fcdds_pkg::FCDDS_RD && MEM_ACK_I) begin
      if (region(ch_dst[s.ch]) == fcdds_pkg::FCDDS_RGN_EE
          || region(ch_dst[s.ch]) == fcdds_pkg::FCDDS_RGN_RSVD) begin
        abort[s.ch] = 1'b1;
      end
    end
    events = {abort, ch_done};
  end

  // Next state of the engine
  always_comb begin
    n = s;
    // APB answers with one wait state
    if (PSEL_I && PENABLE_I && !s.pready) begin
      n.pready  = 1'b1;
      n.pslverr = !hit;
      n.prdata  = PWRITE_I ? 32'h0 : rd_data;
    end else begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      n.prdata  = 32'h0;
    end
    // Global register writes
    if (commit && glob) begin
      unique case (PADDR_I)
        `FCDDS_GCTRL: begin
          n.g_en    = PWDATA_I[`FCDDS_G_EN];
          n.g_rr    = PWDATA_I[`FCDDS_G_RR];
          n.g_eemap = PWDATA_I[`FCDDS_G_EEMAP];
        end
        `FCDDS_ISTAT: n.istat = s.istat & ~PWDATA_I[7:0];
        `FCDDS_IMASK: n.imask = PWDATA_I[7:0];
        default:      n.imask = s.imask;
      endcase
    end
    // flag on completion or abort; set beats clear
    n.istat = n.istat | events;
    n.irq   = |(n.istat & n.imask);
    // Byte mover
    unique case (s.st)
      fcdds_pkg::FCDDS_IDLE: begin
        if (!(s.hold && ch_pend[s.ch])) begin
          n.hold = 1'b0;
        end
        // core first, engine takes idle cycles
        if (s.g_en && any_pend && !CPU_BUS_REQ_I && !abort[pick_ch]) begin
          n.st      = fcdds_pkg::FCDDS_RD;
          n.ch      = pick_ch;
          n.mreq    = 1'b1;
          n.mwe     = 1'b0;
          n.maddr   = ch_src[pick_ch];
          n.mreg    = region(ch_src[pick_ch]);
          if (!(s.hold && ch_pend[s.ch])) begin
            n.rr_last = pick_ch;
          end
        end
      end
      fcdds_pkg::FCDDS_RD: begin
        if (MEM_ACK_I) begin
          if (abort[s.ch]) begin
            n.st   = fcdds_pkg::FCDDS_IDLE;
            n.mreq = 1'b0;
            n.hold = 1'b0;
          end else begin
            n.st     = fcdds_pkg::FCDDS_WR;
            n.mwe    = 1'b1;
            n.maddr  = ch_dst[s.ch];
            n.mreg   = region(ch_dst[s.ch]);
            n.mwdata = MEM_RDATA_I;
          end
        end
      end
      fcdds_pkg::FCDDS_WR: begin
        if (MEM_ACK_I) begin
          n.st   = fcdds_pkg::FCDDS_IDLE;
          n.mreq = 1'b0;
          n.mwe  = 1'b0;
          n.hold = 1'b1;
        end
      end
      default: begin
        n.st   = fcdds_pkg::FCDDS_IDLE;
        n.mreq = 1'b0;
      end
    endcase
  end

  // Engine register
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s         <= '0;
      s.g_en    <= 1'(`FCDDS_GCTRL_RST >> `FCDDS_G_EN);
      s.imask   <= `FCDDS_IMASK_RST;
    end else begin
      s <= n;
    end
  end

  // Four channels
  for (genvar g = 0; g < 4; g++) begin : gen_ch
    fcdds_chan fcdds_chan_inst (
      .clk_i        (CLK_I),
      .rst_i        (RST_I),
      .wr_ctrl_i    (wr_ctrl[g]),
      .wr_src_i     (wr_src[g]),
      .wr_dst_i     (wr_dst[g]),
      .wr_cnt_i     (wr_cnt[g]),
      .wdata_i      (PWDATA_I),
      .trig_i       (TRIG_I[8*g +: 8]),
      .link_start_i (ch_done[g ^ 1] && ch_link[g ^ 1]),
      .byte_done_i  (byte_done[g]),
      .abort_i      (abort[g]),
      .en_o         (ch_en[g]),
      .pend_o       (ch_pend[g]),
      .done_o       (ch_done[g]),
      .link_o       (ch_link[g]),
      .src_o        (ch_src[g]),
      .dst_o        (ch_dst[g]),
      .ctrl_o       (ch_ctrl[g]),
      .cnt_o        (ch_cnt[g])
    );
  end

  // peripherals only by data space address
  assign MEM_REQ_O    = s.mreq;
  assign MEM_WE_O     = s.mwe;
  assign MEM_ADDR_O   = s.maddr;
  assign MEM_WDATA_O  = s.mwdata;
  assign MEM_REGION_O = s.mreg;
  assign PRDATA_O     = s.prdata;
  assign PREADY_O     = s.pready;
  assign PSLVERR_O    = s.pslverr;
  assign IRQ_O        = s.irq;

endmodule

// File: inc/fcdds_map.svh
`ifndef FCDDS_MAP_SVH
`define FCDDS_MAP_SVH

// Global register byte addresses
`define FCDDS_GCTRL        12'h000
`define FCDDS_ISTAT        12'h004
`define FCDDS_IMASK        12'h008
`define FCDDS_STAT         12'h00C

// Channel pages: byte address 0x040 + 0x10 * channel
`define FCDDS_CH_PAGE      6'h01
`define FCDDS_CH_CTRL      4'h0
`define FCDDS_CH_SRC       4'h4
`define FCDDS_CH_DST       4'h8
`define FCDDS_CH_CNT       4'hC

// Global control fields
`define FCDDS_G_EN         0
`define FCDDS_G_RR         1
`define FCDDS_G_EEMAP      2

// Channel control fields
`define FCDDS_CC_EN        0
`define FCDDS_CC_BURST     1
`define FCDDS_CC_SMODE     3
`define FCDDS_CC_DMODE     5
`define FCDDS_CC_RELOAD    7
`define FCDDS_CC_LINK      8
`define FCDDS_CC_TSEL      9
`define FCDDS_CC_SWTRIG    13

// Reset values
`define FCDDS_GCTRL_RST    3'h0
`define FCDDS_IMASK_RST    8'h00

// Data space decode
`define FCDDS_IO_END       16'h0FFF
`define FCDDS_EE_END       16'h1FFF
`define FCDDS_SRAM_BASE    16'h2000
`define FCDDS_SRAM_END     16'h5FFF

`endif

// File: inc/fcdds_pkg.sv
package fcdds_pkg;

  // Byte mover sequence
  typedef enum logic [1:0] {FCDDS_IDLE, FCDDS_RD, FCDDS_WR} fcdds_state_t;

  // Address step per byte
  typedef enum logic [1:0] {
    FCDDS_STEP_HOLD, FCDDS_STEP_INC, FCDDS_STEP_DEC, FCDDS_STEP_HOLD2
  } fcdds_step_t;

  // Data space regions
  typedef enum logic [1:0] {
    FCDDS_RGN_IO, FCDDS_RGN_EE, FCDDS_RGN_SRAM, FCDDS_RGN_RSVD
  } fcdds_region_t;

  // State of one channel
  typedef struct packed {
    logic        en;
    logic [1:0]  burst;
    fcdds_step_t smode;
    fcdds_step_t dmode;
    logic        reload;
    logic        link;
    logic [3:0]  tsel;
    logic [15:0] src0;
    logic [15:0] dst0;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] blk;
    logic [7:0]  rep;
    logic [16:0] blk_left;
    logic [8:0]  rep_left;
    logic [3:0]  burst_left;
    logic        pend;
    logic        done;
  } fcdds_chan_t;

endpackage

// File: core/fcdds_chan.sv
`timescale 1ns/1ns
`include "fcdds_map.svh"

module fcdds_chan (
  input  wire logic        clk_i,        // System clock
  input  wire logic        rst_i,        // Synchronous reset
  input  wire logic        wr_ctrl_i,    // Control word write
  input  wire logic        wr_src_i,     // Source address write
  input  wire logic        wr_dst_i,     // Destination address write
  input  wire logic        wr_cnt_i,     // Count word write
  input  wire logic [31:0] wdata_i,      // Write data
  input  wire logic [7:0]  trig_i,       // This channel's trigger lines
  input  wire logic        link_start_i, // Partner finished, take over
  input  wire logic        byte_done_i,  // One byte moved for this channel
  input  wire logic        abort_i,      // Illegal access, stop channel
  output logic             en_o,         // Channel armed
  output logic             pend_o,       // Burst waiting or in progress
  output logic             done_o,       // Transaction complete pulse
  output logic             link_o,       // Hand over to partner at end
  output logic [15:0]      src_o,        // Current source address
  output logic [15:0]      dst_o,        // Current destination address
  output logic [31:0]      ctrl_o,       // Control readback
  output logic [31:0]      cnt_o         // Count readback
);

  fcdds_pkg::fcdds_chan_t s;
  fcdds_pkg::fcdds_chan_t n;
  logic                   trig;

  // Step an address by the selected mode
  function automatic logic [15:0] step(input logic [15:0] a,
                                       input fcdds_pkg::fcdds_step_t m);
    unique case (m)
      fcdds_pkg::FCDDS_STEP_INC: return 16'(a + 16'h1);
      fcdds_pkg::FCDDS_STEP_DEC: return 16'(a - 16'h1);
      default:                   return a;
    endcase
  endfunction

  // Selected trigger: 0 software only, 1-8 pick a line
  always_comb begin
    trig = (s.tsel != 4'h0) && (s.tsel <= 4'h8) && trig_i[3'(s.tsel - 4'h1)];
  end

  // Next channel state
  always_comb begin
    n = s;
    n.done = 1'b0;
    if (wr_ctrl_i) begin
      n.en     = wdata_i[`FCDDS_CC_EN];
      n.burst  = wdata_i[`FCDDS_CC_BURST +: 2];
      n.smode  = fcdds_pkg::fcdds_step_t'(wdata_i[`FCDDS_CC_SMODE +: 2]);
      n.dmode  = fcdds_pkg::fcdds_step_t'(wdata_i[`FCDDS_CC_DMODE +: 2]);
      n.reload = wdata_i[`FCDDS_CC_RELOAD];
      n.link   = wdata_i[`FCDDS_CC_LINK];
      n.tsel   = wdata_i[`FCDDS_CC_TSEL +: 4];
      if (!wdata_i[`FCDDS_CC_EN]) begin
        n.pend = 1'b0;
      end
    end
    if (wr_src_i) begin
      n.src0 = wdata_i[15:0];
      n.src  = wdata_i[15:0];
    end
    if (wr_dst_i) begin
      n.dst0 = wdata_i[15:0];
      n.dst  = wdata_i[15:0];
    end
    if (wr_cnt_i) begin
      n.blk = wdata_i[15:0];
      n.rep = wdata_i[23:16];
    end
    if (link_start_i) begin
      n.en = 1'b1;
    end
    // Arm counters whenever the channel becomes enabled; zero means the maximum
    if (n.en && !s.en) begin
      n.blk_left = {n.blk == 16'h0, n.blk};
      n.rep_left = {n.rep == 8'h0, n.rep};
      n.pend     = 1'b0;
    end
    // burst of 1, 2, 4 or 8
    if (n.en && !s.pend && (trig || (wr_ctrl_i && wdata_i[`FCDDS_CC_SWTRIG]))) begin
      n.pend       = 1'b1;
      n.burst_left = 4'h1 << n.burst;
    end
    if (byte_done_i && s.pend) begin
      n.src        = step(s.src, s.smode);
      n.dst        = step(s.dst, s.dmode);
      n.blk_left   = 17'(s.blk_left - 17'h1);
      n.burst_left = 4'(s.burst_left - 4'h1);
      if (s.burst_left == 4'h1) begin
        n.pend = 1'b0;
      end
      if (s.blk_left == 17'h1) begin
        n.pend     = 1'b0;
        n.blk_left = {s.blk == 16'h0, s.blk};
        if (s.rep_left == 9'h1) begin
          n.en       = 1'b0;
          n.done     = 1'b1;
          n.rep_left = {s.rep == 8'h0, s.rep};
          if (s.reload) begin
            n.src = s.src0;
            n.dst = s.dst0;
          end
        end else begin
          n.rep_left = 9'(s.rep_left - 9'h1);
        end
      end
    end
    if (abort_i) begin
      n.en   = 1'b0;
      n.pend = 1'b0;
    end
  end

  // Channel register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Readback and status
  assign en_o   = s.en;
  assign pend_o = s.pend;
  assign done_o = s.done;
  assign link_o = s.link;
  assign src_o  = s.src;
  assign dst_o  = s.dst;
  assign ctrl_o = {18'h0, 1'b0, s.tsel, s.link, s.reload, s.dmode, s.smode,
                   s.burst, s.en};
  assign cnt_o  = {8'h0, s.rep, s.blk};

endmodule

// File: testbench/fcdds_props.sv
`timescale 1ns/1ns
module fcdds_props (
  input wire logic        CLK_I,         // Clock
  input wire logic        RST_I,         // Reset
  input wire logic        PSEL_I,        // Select
  input wire logic        PENABLE_I,     // Access
  input wire logic        PWRITE_I,      // Write
  input wire logic [11:0] PADDR_I,       // Address
  input wire logic [31:0] PWDATA_I,      // Wdata
  input wire logic [31:0] PRDATA_O,      // Rdata
  input wire logic        PREADY_O,      // Ready
  input wire logic        PSLVERR_O,     // Error
  input wire logic [31:0] TRIG_I,        // Triggers
  input wire logic        CPU_BUS_REQ_I, // Core bus
  input wire logic        MEM_REQ_O,     // Request
  input wire logic        MEM_WE_O,      // Write
  input wire logic [15:0] MEM_ADDR_O,    // Address
  input wire logic [7:0]  MEM_WDATA_O,   // Wbyte
  input wire logic [1:0]  MEM_REGION_O,  // Region
  input wire logic [7:0]  MEM_RDATA_I,   // Rbyte
  input wire logic        MEM_ACK_I,     // Ack
  input wire logic        IRQ_O          // Irq
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Expected region of a data address
  function automatic logic [1:0] rgn(input logic [15:0] a);
    if (a <= 16'h0FFF) return 2'h0;
    if (a <= 16'h1FFF) return 2'h1;
    if (a <= 16'h5FFF) return 2'h2;
    return 2'h3;
  endfunction
  // Read and write halves of a byte
  sequence s_rd_ack;
    MEM_REQ_O && !MEM_WE_O && MEM_ACK_I;
  endsequence
  sequence s_wr_ack;
    MEM_REQ_O && MEM_WE_O && MEM_ACK_I;
  endsequence
  // APB answer shape
  property p_rdy_one;
    PREADY_O |=> !PREADY_O;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");
  property p_rdy_at;
    PREADY_O |-> PSEL_I && PENABLE_I && $past(PENABLE_I);
  endproperty
  a_rdy_at: assert property (p_rdy_at) else $error("ready outside access");
  property p_rd_idle;
    !PREADY_O |-> PRDATA_O == 32'h00000000 && !PSLVERR_O;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read bus not quiet");
  property p_yield;
    $rose(MEM_REQ_O) |-> !$past(CPU_BUS_REQ_I) && !MEM_WE_O;
  endproperty
  a_yield: assert property (p_yield) else $error("byte began badly");
  property p_hold;
    MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_WE_O);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_wdata;
    s_rd_ack ##1 (MEM_REQ_O && MEM_WE_O) |-> MEM_WDATA_O == $past(MEM_RDATA_I);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write byte differs");
  property p_follow;
    s_rd_ack |=> !MEM_REQ_O || MEM_WE_O;
  endproperty
  a_follow: assert property (p_follow) else $error("read not followed by write");
  property p_gap;
    s_wr_ack |=> !MEM_REQ_O;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after byte");
  property p_dec;
    MEM_REQ_O |-> MEM_REGION_O == rgn(MEM_ADDR_O);
  endproperty
  a_dec: assert property (p_dec) else $error("region decode wrong");
  property p_no_ee;
    MEM_REQ_O && MEM_WE_O |-> MEM_REGION_O == 2'h0 || MEM_REGION_O == 2'h2;
  endproperty
  a_no_ee: assert property (p_no_ee) else $error("illegal write region");
endmodule

// File: testbench/fcdds_mem_model.sv
`timescale 1ns/1ns
module fcdds_mem_model (
  input  wire logic        clk_i,   // Clock
  input  wire logic        rst_i,   // Reset
  input  wire logic        req_i,   // Request
  input  wire logic        we_i,    // Write
  input  wire logic [15:0] addr_i,  // Address
  input  wire logic [7:0]  wdata_i, // Write byte
  input  wire logic [1:0]  lat_i,   // Wait cycles
  output logic      [7:0]  rdata_o, // Read byte
  output logic             ack_o    // Ack pulse
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt;
  // shared bus answers, released data toggles
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
      rdata_o <= 8'h00;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
      rdata_o <= ~rdata_o;
      if (we_i) mem[addr_i] <= wdata_i;
    end else if (req_i && cnt >= lat_i) begin
      ack_o <= 1'b1;
      rdata_o <= we_i ? ~rdata_o : mem[addr_i];
    end else begin
      rdata_o <= ~rdata_o;
      if (req_i) cnt <= cnt + 2'h1;
    end
  end
endmodule

// File: testbench/fcdds_transfer_engine_bench.sv
`timescale 1ns/1ns
`include "fcdds_map.svh"
module fcdds_transfer_engine_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] trig = 32'h0;
  logic        cpu = 1'b0;
  logic [1:0]  lat = 2'h0;
  logic [31:0] prdata, rv;
  logic        pready, pslverr, mreq, mwe, mack, irq, re;
  logic [15:0] maddr;
  logic [7:0]  mwd, mrd;
  logic [1:0]  mrg;
  int          n_errors = 0;
  int          num_checks = 0;
  logic [15:0] es [4] = '{16'h1000, 16'h6000, 16'h2100, 16'h1000};
  logic [15:0] ed [4] = '{16'h2500, 16'h2500, 16'h1000, 16'h2500};
  logic [31:0] eg [4] = '{32'h3, 32'h1, 32'h7, 32'h5};
  logic [31:0] ex [4] = '{32'h10, 32'h10, 32'h10, 32'h01};
  // Clock
  always #50 clk = ~clk;
  fcdds_transfer_engine fcdds_transfer_engine_inst (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TRIG_I(trig), .CPU_BUS_REQ_I(cpu), .MEM_REQ_O(mreq),
    .MEM_WE_O(mwe), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .MEM_REGION_O(mrg),
    .MEM_RDATA_I(mrd), .MEM_ACK_I(mack), .IRQ_O(irq));
  fcdds_mem_model fcdds_mem_model_inst (
    .clk_i(clk), .rst_i(rst), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
    .wdata_i(mwd), .lat_i(lat), .rdata_o(mrd), .ack_o(mack));
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic chkb(input string nm, input logic [7:0] e, input logic [15:0] a);
    num_checks++;
    if (fcdds_mem_model_inst.mem[a] !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, fcdds_mem_model_inst.mem[a]);
      n_errors++;
    end
  endtask
  // APB transfer, result in rv and re
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i >= 20) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [11:0] ca(input int c, input logic [3:0] o);
    return 12'h040 + 12'(c * 16) + 12'(o);
  endfunction
  function automatic logic [31:0] ctl(input int b, sm, dm, rl, lk, ts);
    return 32'h1 | 32'(b) << `FCDDS_CC_BURST | 32'(sm) << `FCDDS_CC_SMODE |
      32'(dm) << `FCDDS_CC_DMODE | 32'(rl) << `FCDDS_CC_RELOAD |
      32'(lk) << `FCDDS_CC_LINK | 32'(ts) << `FCDDS_CC_TSEL;
  endfunction
  task automatic sw(input int c, input logic [31:0] cw);
    wr(ca(c, `FCDDS_CH_CTRL), cw | 32'h2000);
  endtask
  task automatic go(input int c, input logic [15:0] s, d, input logic [31:0] n, cw);
    wr(ca(c, `FCDDS_CH_SRC), {16'h0, s});
    wr(ca(c, `FCDDS_CH_DST), {16'h0, d});
    wr(ca(c, `FCDDS_CH_CNT), n);
    wr(ca(c, `FCDDS_CH_CTRL), cw);
    sw(c, cw);
  endtask
  // Bounded polls of status
  task automatic wait_ist(input logic [31:0] m);
    int i;
    for (i = 0; i < 100; i++) begin
      rd(`FCDDS_ISTAT);
      if ((rv & m) === m) break;
    end
    if (i >= 100) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 100; i++) begin
      rd(`FCDDS_STAT);
      if (rv[3:0] === 4'h0 && rv[8] === 1'b0) break;
    end
    if (i >= 100) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) fcdds_mem_model_inst.mem[16'h2100 + i] = 8'hA0 + 8'(i);
    fcdds_mem_model_inst.mem[16'h1000] = 8'h5A;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      rd(ca(c, `FCDDS_CH_CTRL));
      chk("ctrl", 32'h0, rv);
      rd(ca(c, `FCDDS_CH_CNT));
      chk("cnt", 32'h0, rv);
    end
    rd(`FCDDS_IMASK);
    chk("imask", 32'h0, rv);
    rd(12'h020);
    chk("slverr", 32'h1, {31'h0, re});
    wr(`FCDDS_STAT, 32'hFFFF);
    rd(`FCDDS_STAT);
    chk("stat", 32'h0, rv);
    wr(`FCDDS_GCTRL, 32'h1);
    wr(`FCDDS_IMASK, 32'hFF);
    go(0, 16'h2100, 16'h2200, 32'h0002_0004, ctl(3, 1, 1, 0, 0, 0));
    wait_idle();
    rd(`FCDDS_ISTAT);
    chk("first block", 32'h0, rv);
    sw(0, ctl(3, 1, 1, 0, 0, 0));
    wait_ist(32'h1);
    for (int i = 0; i < 8; i++) chkb("copy", 8'hA0 + 8'(i), 16'h2200 + 16'(i));
    rd(ca(0, `FCDDS_CH_SRC));
    chk("src end", 32'h2108, rv);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`FCDDS_ISTAT, 32'h1);
    rd(`FCDDS_ISTAT);
    chk("irq", 32'h0, {31'h0, irq});
    lat <= 2'h2;
    wr(`FCDDS_IMASK, 32'h0);
    go(1, 16'h2105, 16'h0100, 32'h0001_0003, ctl(0, 2, 0, 1, 0, 0));
    wait_idle();
    rd(ca(1, `FCDDS_CH_SRC));
    chk("one byte", 32'h2104, rv);
    chkb("io dst", 8'hA5, 16'h0100);
    sw(1, ctl(0, 2, 0, 1, 0, 0));
    wait_idle();
    sw(1, ctl(0, 2, 0, 1, 0, 0));
    wait_ist(32'h2);
    chkb("io dst", 8'hA3, 16'h0100);
    rd(ca(1, `FCDDS_CH_SRC));
    chk("reload", 32'h2105, rv);
    chk("masked", 32'h0, {31'h0, irq});
    wr(`FCDDS_IMASK, 32'h2);
    rd(`FCDDS_ISTAT);
    chk("istat", 32'h2, rv);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`FCDDS_ISTAT, 32'h2);
    rd(`FCDDS_ISTAT);
    chk("irq", 32'h0, {31'h0, irq});
    lat <= 2'h0;
    go(3, 16'h2300, 16'h2400, 32'h0001_0002, ctl(0, 1, 1, 0, 0, 0) & ~32'h1);
    go(2, 16'h2100, 16'h2300, 32'h0001_0006, ctl(1, 1, 1, 0, 1, 3));
    wait_idle();
    trig[18] <= 1'b1;
    @(posedge clk);
    trig[18] <= 1'b0;
    wait_idle();
    rd(ca(2, `FCDDS_CH_SRC));
    chk("burst two", 32'h2104, rv);
    @(posedge clk);
    trig[18] <= 1'b1;
    @(posedge clk);
    trig[18] <= 1'b0;
    wait_ist(32'h4);
    rd(`FCDDS_STAT);
    chk("link", 32'h8, {28'h0, rv[7:4]});
    sw(3, ctl(1, 1, 1, 0, 0, 0));
    wait_ist(32'h8);
    chkb("linked", 8'hA3, 16'h2303);
    chkb("linked", 8'hA1, 16'h2401);
    lat <= 2'h1;
    for (int k = 0; k < 4; k++) begin
      wr(`FCDDS_ISTAT, 32'hFF);
      wr(`FCDDS_GCTRL, eg[k]);
      go(0, es[k], ed[k], 32'h0001_0001, ctl(0, 1, 1, 0, 0, 0));
      wait_ist(ex[k]);
      chk("legal", ex[k], rv);
    end
    chkb("eeprom read", 8'h5A, 16'h2500);
    wr(`FCDDS_ISTAT, 32'hFF);
    cpu <= 1'b1;
    go(0, 16'h2100, 16'h2600, 32'h0001_0001, ctl(0, 1, 1, 0, 0, 0));
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      chk("core holds", 32'h0, {31'h0, mreq});
    end
    cpu <= 1'b0;
    wait_ist(32'h1);
    chkb("after core", 8'hA0, 16'h2600);
    give_verdict();
  end
endmodule
bind fcdds_transfer_engine fcdds_props fcdds_props_inst (
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TRIG_I(TRIG_I),
  .CPU_BUS_REQ_I(CPU_BUS_REQ_I), .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O),
  .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .MEM_REGION_O(MEM_REGION_O),
  .MEM_RDATA_I(MEM_RDATA_I), .MEM_ACK_I(MEM_ACK_I), .IRQ_O(IRQ_O));
